// ==== hdl/mcr_top.v ====
`timescale 1ns/1ps
`include "mcr_defines.vh"
// ----------------------------------------------------------------
// Measurement setup and identification registers, serial-bus slave
// ----------------------------------------------------------------
module mcr_top #(
    parameter [6:0]  BUS_ADDR   = 7'h40,            // Slave address
    parameter [15:0] MAKER_CODE = 16'h1234,         // Arbitrary value
    parameter [15:0] PART_CODE  = 16'h0abc,         // Arbitrary value
    parameter [35:0] PER_R1     = `MCR_CYC(`MCR_T_R1_MS),
    parameter [35:0] PER_R2     = `MCR_CYC(`MCR_T_R2_MS),
    parameter [35:0] PER_R3     = `MCR_CYC(`MCR_T_R3_MS),
    parameter [35:0] PER_R4     = `MCR_CYC(`MCR_T_R4_MS),
    parameter [35:0] PER_R5     = `MCR_CYC(`MCR_T_R5_MS),
    parameter [35:0] PER_R6     = `MCR_CYC(`MCR_T_R6_MS),
    parameter [35:0] PER_R7     = `MCR_CYC(`MCR_T_R7_MS)
) (
    input  wire       clock_in,        // 50 MHz system clock
    input  wire       sys_rst_in,      // Synchronous reset, high
    input  wire       scl_in,          // Serial clock pin
    input  wire       sda_in,          // Serial data pin level
    output wire       sda_out_out,     // Serial data drive value
    output wire       sda_oe_out,      // High while pulling data low
    input  wire       conv_busy_in,    // Converter busy, same clock
    output wire       meas_start_out,  // One-cycle conversion start
    output wire [1:0] temp_res_out,    // Temperature resolution code
    output wire [1:0] humid_res_out,   // Humidity resolution code
    output wire [3:0] temp_bits_out,   // Temperature width, 0 invalid
    output wire [3:0] humid_bits_out,  // Humidity width, 0 invalid
    output wire       temp_en_out,     // Temperature channel converts
    output wire       humid_en_out,    // Humidity channel converts
    output wire       continuous_out   // Repeated sampling running
);
    // ------------------------------------------------------------
    // State encodings, one-hot
    // ------------------------------------------------------------
    localparam [6:0] ST_IDLE = 7'h01; // Not addressed
    localparam [6:0] ST_ADDR = 7'h02; // Shifting slave address
    localparam [6:0] ST_AACK = 7'h04; // Acking address
    localparam [6:0] ST_WR   = 7'h08; // Shifting write byte
    localparam [6:0] ST_WACK = 7'h10; // Acking write byte
    localparam [6:0] ST_RD   = 7'h20; // Sending read byte
    localparam [6:0] ST_RACK = 7'h40; // Host ack of read byte

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    wire [1:0]  pin_sync;          // Synchronised scl, sda
    wire        scl_s;             // Synced clock level
    wire        sda_s;             // Synced data level
    reg         scl_d_reg;         // Delayed clock level
    reg         sda_d_reg;         // Delayed data level
    wire        scl_rise;          // Clock rising edge
    wire        scl_fall;          // Clock falling edge
    wire        bus_start;         // Start or repeated start
    wire        bus_stop;          // Stop condition
    reg  [6:0]  state_reg;         // Slave state
    reg  [3:0]  bit_cnt_reg;       // Bits seen in current byte
    reg  [7:0]  rx_reg;            // Receive shift register
    reg  [7:0]  tx_reg;            // Transmit shift register
    reg  [7:0]  ptr_reg;           // Register pointer
    reg         ptr_phase_reg;     // Next write byte is pointer
    reg         rw_reg;            // Transfer direction, 1 read
    reg         host_ack_reg;      // Host acked last read byte
    reg         oe_reg;            // Data pull-down enable
    reg         wr_stb_reg;        // One-cycle register write
    reg  [7:0]  wr_addr_reg;       // Write target offset
    reg  [7:0]  wr_data_reg;       // Write data
    reg  [7:0]  rd_data;           // Read mux output
    reg  [7:0]  setup_reg;         // Measurement setup register
    reg  [6:0]  dev_cfg_reg;       // Conversion rate and misc bits
    reg         running_reg;       // Continuous sampling active
    reg  [35:0] timer_reg;         // Cycles since last start
    reg  [35:0] period;            // Selected sampling period
    reg         start_reg;         // Start pulse
    reg  [3:0]  tbits_reg;         // Decoded temperature width
    reg  [3:0]  hbits_reg;         // Decoded humidity width
    reg         ten_reg;           // Temperature enable
    reg         hen_reg;           // Humidity enable
    wire [2:0]  rate;              // Conversion rate field
    wire        trig_go;           // Triggered start this cycle
    wire        tick_go;           // Periodic start this cycle

    // ------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------
    mcr_sync #(
        .WIDTH   (2),
        .RST_VAL (2'h3)
    ) u_sync (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .async_in   ({scl_in, sda_in}),
        .sync_out   (pin_sync)
    );

    assign scl_s = pin_sync[1];
    assign sda_s = pin_sync[0];

    // Delay stage for edges, reads only synchronised levels
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_d_reg;
    assign scl_fall  = ~scl_s & scl_d_reg;
    assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign bus_stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    // Unmapped offsets read as zero; reserved bit 7 of config too
    always @* begin
        case (ptr_reg)
            `MCR_ADDR_DEV_CFG:  rd_data = {1'b0, dev_cfg_reg};
            `MCR_ADDR_SETUP:    rd_data = setup_reg;
            `MCR_ADDR_MAKER_LO: rd_data = MAKER_CODE[7:0];
            `MCR_ADDR_MAKER_HI: rd_data = MAKER_CODE[15:8];
            `MCR_ADDR_PART_LO:  rd_data = PART_CODE[7:0];
            `MCR_ADDR_PART_HI:  rd_data = PART_CODE[15:8];
            default:            rd_data = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Serial-bus slave
    // ------------------------------------------------------------
    // Data changes only on clock falls, so the host sees it stable
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            state_reg     <= ST_IDLE;
            bit_cnt_reg   <= 4'h0;
            rx_reg        <= 8'h00;
            tx_reg        <= 8'h00;
            ptr_reg       <= 8'h00;
            ptr_phase_reg <= 1'b0;
            rw_reg        <= 1'b0;
            host_ack_reg  <= 1'b0;
            oe_reg        <= 1'b0;
            wr_stb_reg    <= 1'b0;
            wr_addr_reg   <= 8'h00;
            wr_data_reg   <= 8'h00;
        end else begin
            wr_stb_reg <= 1'b0;
            if (bus_start) begin
                // Start wins in any state, also repeated start
                state_reg   <= ST_ADDR;
                bit_cnt_reg <= 4'h0;
                oe_reg      <= 1'b0;
            end else if (bus_stop) begin
                state_reg <= ST_IDLE;
                oe_reg    <= 1'b0;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        oe_reg <= 1'b0;
                    end
                    ST_ADDR, ST_WR: begin
                        if (scl_rise) begin
                            rx_reg      <= {rx_reg[6:0], sda_s};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                            bit_cnt_reg <= 4'h0;
                            if (state_reg == ST_ADDR) begin
                                if (rx_reg[7:1] == BUS_ADDR) begin
                                    rw_reg        <= rx_reg[0];
                                    ptr_phase_reg <= ~rx_reg[0];
                                    oe_reg        <= 1'b1;
                                    state_reg     <= ST_AACK;
                                end else begin
                                    state_reg <= ST_IDLE;
                                end
                            end else begin
                                oe_reg    <= 1'b1;
                                state_reg <= ST_WACK;
                                if (ptr_phase_reg) begin
                                    ptr_reg       <= rx_reg;
                                    ptr_phase_reg <= 1'b0;
                                end else begin
                                    wr_stb_reg  <= 1'b1;
                                    wr_addr_reg <= ptr_reg;
                                    wr_data_reg <= rx_reg;
                                    ptr_reg     <= ptr_reg + 8'h01;
                                end
                            end
                        end
                    end
                    ST_AACK: begin
                        if (scl_fall) begin
                            if (rw_reg) begin
                                tx_reg    <= rd_data;
                                oe_reg    <= ~rd_data[7];
                                ptr_reg   <= ptr_reg + 8'h01;
                                state_reg <= ST_RD;
                            end else begin
                                oe_reg    <= 1'b0;
                                state_reg <= ST_WR;
                            end
                        end
                    end
                    ST_WACK: begin
                        if (scl_fall) begin
                            oe_reg    <= 1'b0;
                            state_reg <= ST_WR;
                        end
                    end
                    ST_RD: begin
                        if (scl_rise) begin
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt_reg == 4'h8) begin
                                bit_cnt_reg <= 4'h0;
                                oe_reg      <= 1'b0;
                                state_reg   <= ST_RACK;
                            end else begin
                                tx_reg <= {tx_reg[6:0], 1'b0};
                                oe_reg <= ~tx_reg[6];
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            host_ack_reg <= ~sda_s;
                        end else if (scl_fall) begin
                            // Nack ends the read; back to idle until the next start
                            if (host_ack_reg) begin
                                tx_reg    <= rd_data;
                                oe_reg    <= ~rd_data[7];
                                ptr_reg   <= ptr_reg + 8'h01;
                                state_reg <= ST_RD;
                            end else begin
                                state_reg <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                        oe_reg    <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Register file and measurement sequencer
    // ------------------------------------------------------------
    assign rate    = dev_cfg_reg[`MCR_RATE_MSB:`MCR_RATE_LSB];
    // Starts wait for an idle converter so none is dropped
    assign trig_go = setup_reg[`MCR_TRIG_BIT] & ~conv_busy_in;
    assign tick_go = running_reg & ~trig_go & ~conv_busy_in &
                     (timer_reg >= period - 36'd1);

    // Period per rate code; code 000 never reaches the timer
    always @* begin
        case (rate)
            3'h1:    period = PER_R1;
            3'h2:    period = PER_R2;
            3'h3:    period = PER_R3;
            3'h4:    period = PER_R4;
            3'h5:    period = PER_R5;
            3'h6:    period = PER_R6;
            3'h7:    period = PER_R7;
            default: period = PER_R1;
        endcase
    end

    // A host write to the trigger wins over the hardware clear
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            setup_reg   <= `MCR_SETUP_RST;
            dev_cfg_reg <= `MCR_DEV_CFG_RST;
            running_reg <= 1'b0;
            timer_reg   <= 36'd0;
            start_reg   <= 1'b0;
        end else begin
            start_reg <= trig_go | tick_go;
            if (trig_go) begin
                setup_reg[`MCR_TRIG_BIT] <= 1'b0;
            end
            if (wr_stb_reg && wr_addr_reg == `MCR_ADDR_SETUP) begin
                setup_reg[7:1] <= wr_data_reg[7:1];
                // Zero leaves a pending trigger alone
                if (wr_data_reg[`MCR_TRIG_BIT]) begin
                    setup_reg[`MCR_TRIG_BIT] <= 1'b1;
                end
            end
            if (wr_stb_reg && wr_addr_reg == `MCR_ADDR_DEV_CFG) begin
                dev_cfg_reg <= wr_data_reg[6:0];
            end
            if (rate == `MCR_RATE_ONESHOT) begin
                running_reg <= 1'b0;
                timer_reg   <= 36'd0;
            end else if (trig_go || tick_go) begin
                running_reg <= 1'b1;
                timer_reg   <= 36'd0;
            end else if (running_reg && timer_reg < period) begin
                // Saturates while the converter is still busy
                timer_reg <= timer_reg + 36'd1;
            end
        end
    end

    // ------------------------------------------------------------
    // Decoded converter settings
    // ------------------------------------------------------------
    // Code 11 gives width 0 so the converter can flag it
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            tbits_reg <= 4'h0;
            hbits_reg <= 4'h0;
            ten_reg   <= 1'b0;
            hen_reg   <= 1'b0;
        end else begin
            case (setup_reg[`MCR_TRES_MSB:`MCR_TRES_LSB])
                `MCR_RES_14: tbits_reg <= 4'he;
                `MCR_RES_11: tbits_reg <= 4'hb;
                `MCR_RES_9:  tbits_reg <= 4'h9;
                default:     tbits_reg <= 4'h0;
            endcase
            case (setup_reg[`MCR_HRES_MSB:`MCR_HRES_LSB])
                `MCR_RES_14: hbits_reg <= 4'he;
                `MCR_RES_11: hbits_reg <= 4'hb;
                `MCR_RES_9:  hbits_reg <= 4'h9;
                default:     hbits_reg <= 4'h0;
            endcase
            case (setup_reg[`MCR_SEL_MSB:`MCR_SEL_LSB])
                `MCR_SEL_BOTH: begin
                    ten_reg <= 1'b1;
                    hen_reg <= 1'b1;
                end
                `MCR_SEL_TEMP: begin
                    ten_reg <= 1'b1;
                    hen_reg <= 1'b0;
                end
                default: begin
                    ten_reg <= 1'b0;
                    hen_reg <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign sda_out_out    = 1'b0;
    assign sda_oe_out     = oe_reg;
    assign meas_start_out = start_reg;
    assign temp_res_out   = setup_reg[`MCR_TRES_MSB:`MCR_TRES_LSB];
    assign humid_res_out  = setup_reg[`MCR_HRES_MSB:`MCR_HRES_LSB];
    assign temp_bits_out  = tbits_reg;
    assign humid_bits_out = hbits_reg;
    assign temp_en_out    = ten_reg;
    assign humid_en_out   = hen_reg;
    assign continuous_out = running_reg;
endmodule // mcr_top

// ==== hdl/mcr_defines.vh ====
`ifndef MCR_DEFINES_VH
`define MCR_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define MCR_ADDR_DEV_CFG      8'h0e
`define MCR_ADDR_SETUP        8'h0f
`define MCR_ADDR_MAKER_LO     8'hfc
`define MCR_ADDR_MAKER_HI     8'hfd
`define MCR_ADDR_PART_LO      8'hfe
`define MCR_ADDR_PART_HI      8'hff

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MCR_TRES_MSB          7
`define MCR_TRES_LSB          6
`define MCR_HRES_MSB          5
`define MCR_HRES_LSB          4
`define MCR_RSVD_BIT          3
`define MCR_SEL_MSB           2
`define MCR_SEL_LSB           1
`define MCR_TRIG_BIT          0
`define MCR_RATE_MSB          6
`define MCR_RATE_LSB          4

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define MCR_SETUP_RST         8'h00
`define MCR_DEV_CFG_RST       7'h00
`define MCR_RES_14            2'h0
`define MCR_RES_11            2'h1
`define MCR_RES_9             2'h2
`define MCR_SEL_BOTH          2'h0
`define MCR_SEL_TEMP          2'h1
`define MCR_RATE_ONESHOT      3'h0

// ----------------------------------------------------------------
// Timing: sampling periods in ms and cycles at 50 MHz
// ----------------------------------------------------------------
`define MCR_CYC_PER_MS        36'd50000
`define MCR_T_R1_MS           36'd120000
`define MCR_T_R2_MS           36'd60000
`define MCR_T_R3_MS           36'd10000
`define MCR_T_R4_MS           36'd5000
`define MCR_T_R5_MS           36'd1000
`define MCR_T_R6_MS           36'd500
`define MCR_T_R7_MS           36'd200
`define MCR_CYC(ms)           ((ms) * `MCR_CYC_PER_MS)

`endif

// ==== hdl/mcr_sync.v ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two-flop synchroniser for pin inputs
// ----------------------------------------------------------------
module mcr_sync #(
    parameter             WIDTH   = 2,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
    input  wire             clock_in,   // System clock
    input  wire             sys_rst_in, // Synchronous reset
    input  wire [WIDTH-1:0] async_in,   // Raw pin levels
    output wire [WIDTH-1:0] sync_out    // Levels in clock domain
);
    reg [WIDTH-1:0] meta_reg;  // First stage, read only by second
    reg [WIDTH-1:0] stable_reg; // Second stage

    // Idle bus level is high, so reset to RST_VAL avoids fake edges
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            meta_reg   <= RST_VAL;
            stable_reg <= RST_VAL;
        end else begin
            meta_reg   <= async_in;
            stable_reg <= meta_reg;
        end
    end

    assign sync_out = stable_reg;
endmodule // mcr_sync

// ==== bench/mcr_host.sv ====
`timescale 1ns/1ps
// ------------------------------------------
// Serial bus host, data line open drain
// ------------------------------------------
module mcr_host (
    input  wire clock_in,
    input  wire sda_in,
    output reg  scl_out,
    output reg  sda_low_out
);
    reg smp; // Data level sampled while clock high
    initial {scl_out, sda_low_out, smp} = 3'h4; // Bus idles high
    // Let n edges pass, act just after the last
    task hc(input integer n);
        begin
            repeat (n) @(posedge clock_in);
            #1;
        end
    endtask
    // Clock pulse; data a before rise, b while high; a != b marks start or stop
    task step(input a, input b, input fall);
        begin
            sda_low_out = a;
            hc(8);
            scl_out = 1'b1;
            hc(8);
            smp = sda_in;
            sda_low_out = b;
            hc(8);
            scl_out = !fall;
            hc(3);
        end
    endtask
    // Byte msb first, then ninth bit left in smp; 0 means acknowledged
    task xfer(input [7:0] d, input last, output [7:0] q);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                step(!d[i], !d[i], 1'b1);
                q[i] = smp;
            end
            step(!last, !last, 1'b1);
        end
    endtask
endmodule // mcr_host

// ==== bench/mcr_monitor.sv ====
`timescale 1ns/1ps
// ------------------------------------------
// Pin checker for the setup bank
// ------------------------------------------
module mcr_monitor (
    input wire       clock_in,
    input wire       sys_rst_in,
    input wire       sda_out_out,
    input wire       sda_oe_out,
    input wire       meas_start_out,
    input wire [1:0] temp_res_out,
    input wire [1:0] humid_res_out,
    input wire [3:0] temp_bits_out,
    input wire [3:0] humid_bits_out,
    input wire       temp_en_out,
    input wire       humid_en_out,
    input wire       continuous_out
);
    // Width per code; zero marks the unusable code
    function [3:0] bw(input [1:0] c);
        bw = c[1] ? (c[0] ? 4'h0 : 4'h9) : (c[0] ? 4'hb : 4'he);
    endfunction
    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    a_temp_width: assert property (!$past(sys_rst_in) |-> temp_bits_out == bw($past(temp_res_out)))
        else $error("temperature width wrong");
    a_humid_width: assert property (!$past(sys_rst_in) |-> humid_bits_out == bw($past(humid_res_out)))
        else $error("humidity width wrong");
    a_enable_pair: assert property (humid_en_out |-> temp_en_out)
        else $error("humidity without temperature");
    a_start_gap: assert property (meas_start_out |=> !meas_start_out [*8])
        else $error("start pulses too close");
    a_kick_start: assert property ($rose(continuous_out) |-> ##[0:2] meas_start_out)
        else $error("repeated mode began without start");
    a_reset_quiet: assert property (disable iff (1'b0)
        $past(sys_rst_in) |-> !(meas_start_out || sda_oe_out || continuous_out)) else $error("busy after reset");
    a_drive_low: assert property (sda_out_out == 1'b0)
        else $error("data drive not low");
    a_ack_hold: assert property ($rose(sda_oe_out) |=> sda_oe_out [*8])
        else $error("data pull too short");
    c_start: cover property (meas_start_out);
    c_ack: cover property ($rose(sda_oe_out));
    c_repeat: cover property (continuous_out && meas_start_out);
endmodule // mcr_monitor
bind mcr_top mcr_monitor u_mon (.*);

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
// ------------------------------------------
// Bench: host model on the bus, busy level driven here
// ------------------------------------------
module testbench;
    localparam [15:0] MK = 16'h2c6e; // Arbitrary value
    localparam [15:0] PT = 16'h0b3d; // Arbitrary value
    localparam [35:0] P [1:7] = '{36'hc8, 36'h96, 36'h64, 36'h50, 36'h32, 36'h1e, 36'h14}; // Short periods
    reg        clock_in = 1'b0;
    reg        sys_rst_in = 1'b1;
    reg        conv_busy_in = 1'b0;
    wire       scl_in, sda_in, sda_out_out, sda_oe_out, meas_start_out, host_low;
    wire       temp_en_out, humid_en_out, continuous_out;
    wire [1:0] temp_res_out, humid_res_out;
    wire [3:0] temp_bits_out, humid_bits_out;
    integer    fails = 0, n_tests = 0, seed = 30171, starts = 0, s0, i;
    reg  [7:0] q [$];
    reg  [7:0] d, t, rd_val;
    event      rd_ev;
    assign sda_in = (sda_oe_out ? sda_out_out : 1'b1) & ~host_low; // Pull-up when released
    mcr_top #(.MAKER_CODE(MK), .PART_CODE(PT), .PER_R1(P[1]), .PER_R2(P[2]), .PER_R3(P[3]),
        .PER_R4(P[4]), .PER_R5(P[5]), .PER_R6(P[6]), .PER_R7(P[7])) DUT (.*);
    mcr_host H (.clock_in(clock_in), .sda_in(sda_in), .scl_out(scl_in), .sda_low_out(host_low));
    initial forever #10 clock_in = ~clock_in;
    always @(posedge clock_in) starts <= starts + (meas_start_out === 1'b1);
    always @(rd_ev) chk("read data", q.pop_front(), rd_val);
    initial begin
        #2000000;
        fails = fails + 1;
        stop_test;
    end
    function [3:0] w(input [1:0] c);
        w = c == 2'h0 ? 4'he : c == 2'h1 ? 4'hb : c == 2'h2 ? 4'h9 : 4'h0;
    endfunction
    task chk(input string nm, input [7:0] e, input [7:0] g);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("BAD %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task wreg(input [7:0] a, input [7:0] v);
        begin
            H.step(1'b0, 1'b1, 1'b1);
            H.xfer(8'h80, 1'b1, t);
            H.xfer(a, 1'b1, t);
            H.xfer(v, 1'b1, t);
            chk("write ack", 8'h00, {7'h0, H.smp});
            H.step(1'b1, 1'b0, 1'b0);
        end
    endtask
    // Pointer write, repeated start, one byte with closing nack
    task rreg(input [7:0] a, input [7:0] e);
        begin
            q.push_back(e);
            H.step(1'b0, 1'b1, 1'b1);
            H.xfer(8'h80, 1'b1, t);
            H.xfer(a, 1'b1, t);
            H.step(1'b0, 1'b1, 1'b1);
            H.xfer(8'h81, 1'b1, t);
            H.xfer(8'hff, 1'b1, rd_val);
            H.step(1'b1, 1'b0, 1'b0);
            -> rd_ev;
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", n_tests, fails);
            if (fails == 0 && n_tests > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    initial begin
        repeat (5) @(posedge clock_in);
        #1 sys_rst_in = 1'b0;
        H.hc(5);
        wreg(8'hfc, 8'h5a); // Identification must ignore this
        for (i = 0; i < 4; i = i + 1) begin
            rreg(8'hfc + i[7:0], i[1] ? PT[8 * i[0] +: 8] : MK[8 * i[0] +: 8]);
        end
        H.step(1'b0, 1'b1, 1'b1);
        H.xfer(8'h82, 1'b1, t);
        chk("foreign ack", 8'h01, {7'h0, H.smp});
        H.step(1'b1, 1'b0, 1'b0);
        $display("identification test done");
        for (i = 0; i < 4; i = i + 1) begin
            t = $random(seed);
            conv_busy_in = t[0]; // Busy level must not matter while no trigger is pending
            d = {i[1:0], ~i[1:0], t[3:1], 1'b0};
            s0 = starts;
            wreg(8'h0f, d);
            chk("temp width", {4'h0, w(d[7:6])}, {4'h0, temp_bits_out});
            chk("humid width", {4'h0, w(d[5:4])}, {4'h0, humid_bits_out});
            chk("res codes", {4'h0, d[7:4]}, {4'h0, temp_res_out, humid_res_out});
            chk("enables", {6'h0, d[2:1] < 2'h2, d[2:1] == 2'h0}, {6'h0, temp_en_out, humid_en_out});
            rreg(8'h0f, d);
            chk("idle starts", s0[7:0], starts[7:0]);
        end
        $display("setup field test done");
        conv_busy_in = 1'b1;
        s0 = starts;
        wreg(8'h0f, 8'h01);
        H.hc(20);
        chk("start while busy", s0[7:0], starts[7:0]);
        conv_busy_in = 1'b0;
        H.hc(5);
        chk("one shot", s0[7:0] + 8'h01, starts[7:0]);
        rreg(8'h0f, 8'h00);
        $display("one shot test done");
        // Fast codes only prove decoding; scaled periods, no sensor to heat
        for (i = 1; i < 8; i = i + 1) begin
            wreg(8'h0e, {1'b1, i[2:0], 4'h0}); // Top bit is not stored
            wreg(8'h0f, 8'h01);
            H.hc(40);
            s0 = starts;
            H.hc(1200);
            chk("rate starts", 8'(1200 / P[i]), 8'(starts - s0));
            chk("running", 8'h01, {7'h0, continuous_out});
            rreg(8'h0e, {1'b0, i[2:0], 4'h0});
            wreg(8'h0e, 8'h00);
            s0 = starts;
            H.hc(400);
            chk("stopped", s0[7:0], starts[7:0]);
        end
        $display("rate test done");
        stop_test;
    end
endmodule // testbench
